// [pkg/rss_regs.svh]
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define RSS_CLK_MHZ 25
`define RSS_T_POWERON_US 185
`define RSS_POWERON_CYC (`RSS_T_POWERON_US * `RSS_CLK_MHZ)
`define RSS_T_POWERON_MAX_US 500
`define RSS_POWERON_MAX_CYC (`RSS_T_POWERON_MAX_US * `RSS_CLK_MHZ)
`define RSS_T_SLEEP_WAKE_US 1
`define RSS_SLEEP_WAKE_CYC (`RSS_T_SLEEP_WAKE_US * `RSS_CLK_MHZ)
`define RSS_T_RESET_US 1
`define RSS_RESET_CYC (`RSS_T_RESET_US * `RSS_CLK_MHZ)
`define RSS_T_PREP_US 90
`define RSS_PREP_CYC (`RSS_T_PREP_US * `RSS_CLK_MHZ)
`define RSS_T_PREP_MAX_US 200
`define RSS_PREP_MAX_CYC (`RSS_T_PREP_MAX_US * `RSS_CLK_MHZ)
`define RSS_T_TXSTART_US 4
`define RSS_TXSTART_CYC (`RSS_T_TXSTART_US * `RSS_CLK_MHZ)
`define RSS_T_RAMP_STEP_US 8
`define RSS_RAMP_STEP_CYC (`RSS_T_RAMP_STEP_US * `RSS_CLK_MHZ)
`define RSS_T_RAMPDN_MAX_US 33
`define RSS_RAMPDN_MAX_CYC (`RSS_T_RAMPDN_MAX_US * `RSS_CLK_MHZ)
`define RSS_PARAMP_REF 2'h3
`define RSS_T_PLL_US 50
`define RSS_PLL_CYC (`RSS_T_PLL_US * `RSS_CLK_MHZ)
`define RSS_T_PLL_MIN_US 10
`define RSS_PLL_MIN_CYC (`RSS_T_PLL_MIN_US * `RSS_CLK_MHZ)
`define RSS_T_PLL_MAX_US 100
`define RSS_PLL_MAX_CYC (`RSS_T_PLL_MAX_US * `RSS_CLK_MHZ)
`define RSS_T_RX_FRAME_END_IRQ_US 20
`define RSS_RX_FRAME_END_IRQ_CYC (`RSS_T_RX_FRAME_END_IRQ_US * `RSS_CLK_MHZ)
`define RSS_TIMER_W 16
`endif

// [pkg/rss_pkg.sv]
package rss_pkg;

  typedef enum logic [2:0]
  {
    CMD_NOP,
    CMD_SLEEP,
    CMD_DEEP_SLEEP,
    CMD_OFF,
    CMD_PREP,
    CMD_TX,
    CMD_RX
  } rss_cmd_type;

  typedef enum logic [3:0]
  {
    ST_POR,
    ST_RST,
    ST_SLEEP,
    ST_DEEP,
    ST_WAKE,
    ST_WAKE_DEEP,
    ST_OFF,
    ST_PREP_SETTLE,
    ST_RX_SETTLE,
    ST_PREP,
    ST_RX,
    ST_TX,
    ST_RAMPDN
  } rss_state_type;

endpackage

// [pkg/rss_tmr_if.sv]
`timescale 1ns/10ps
interface rss_tmr_if
#(
  parameter int W = 16
);
  logic         load;
  logic [W-1:0] load_val;
  logic         done;
  logic         busy;

  modport ctl (output load, output load_val, input done, input busy);
  modport tmr (input load, input load_val, output done, output busy);
endinterface

// [src/rss_sync.sv]
`timescale 1ns/10ps
module rss_sync
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      sync_o
);
  logic meta_r;

  // Idle level is released, so power-on is not taken for a pin reset
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      meta_r <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta_r <= pin_i;
      sync_o <= meta_r;
    end
endmodule

// [src/rss_timer.sv]
`timescale 1ns/10ps
module rss_timer
#(
  parameter int W = 16
)
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  rss_tmr_if.tmr    bus
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      cnt_r <= '0;
    else if (bus.load)
      cnt_r <= bus.load_val;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;

  // A reload in the expiry cycle wins, so the old count never fires
  assign bus.done = (cnt_r == W'(1)) && !bus.load;
  assign bus.busy = (cnt_r != '0);
endmodule

// [src/rss_top.sv]
`timescale 1ns/10ps
`include "rss_regs.svh"
module rss_top
#(
  parameter int unsigned POWERON_CYC = `RSS_POWERON_CYC,
  parameter int unsigned PREP_CYC    = `RSS_PREP_CYC
)
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  hw_reset_input_n_i,
  input  wire logic                  cmd_valid_i,
  input  wire rss_pkg::rss_cmd_type  cmd_i,
  input  wire logic                  rx_valid_end_i,
  input  wire logic                  tx_frame_end_i,
  input  wire logic                  chan_change_i,
  input  wire logic [1:0]            pa_ramp_time_field_i,
  output rss_pkg::rss_state_type     state_o,
  output logic                       power_up_done_irq_o,
  output logic                       radio_ready_irq_o,
  output logic                       rx_frame_end_irq_o,
  output logic                       clock_out_pin_o,
  output logic                       pa_ramp_start_o,
  output logic                       pa_on_o,
  output logic                       pll_locked_o
);
  localparam int TW = `RSS_TIMER_W;

  rss_pkg::rss_state_type state_r;
  rss_pkg::rss_state_type state_nxt;
  logic                   hw_rst_n_s;
  logic                   por_arm_r;
  logic                   clock_out_pin_run_r;
  logic                   cmd_go;
  logic                   radio_on_nxt;
  logic [TW-1:0]          st_cnt_r;
  logic [TW-1:0]          pll_cnt_r;

  // ****************************************************************
  // Timers: 0 state moves, 1 synthesiser, 2 frame-end processing
  // ****************************************************************
  rss_tmr_if #(.W(TW)) tmr [3] ();

  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_tmr
      rss_timer #(.W(TW)) u_tmr
      (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .bus     (tmr[g])
      );
    end
  endgenerate

  rss_sync u_rst_sync
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (hw_reset_input_n_i),
    .sync_o  (hw_rst_n_s)
  );

  // Command strobe marks the last serial clock edge of the value byte
  assign cmd_go = cmd_valid_i && hw_rst_n_s;

  // ****************************************************************
  // State sequencing
  // ****************************************************************
  always_comb
  begin
    state_nxt        = state_r;
    tmr[0].load      = 1'b0;
    tmr[0].load_val  = '0;
    if (!hw_rst_n_s)
    begin
      // Held loaded while the pin is low; counting starts at release
      state_nxt       = rss_pkg::ST_RST;
      tmr[0].load     = 1'b1;
      tmr[0].load_val = TW'(`RSS_RESET_CYC);
    end
    else
    begin
      case (state_r)
        rss_pkg::ST_POR:
        begin
          tmr[0].load     = por_arm_r;
          tmr[0].load_val = TW'(POWERON_CYC);
          if (tmr[0].done)
            state_nxt = rss_pkg::ST_OFF;
        end
        rss_pkg::ST_RST, rss_pkg::ST_WAKE, rss_pkg::ST_WAKE_DEEP:
          if (tmr[0].done)
            state_nxt = rss_pkg::ST_OFF;
        rss_pkg::ST_SLEEP:
          if (cmd_go && cmd_i == rss_pkg::CMD_OFF)
          begin
            state_nxt       = rss_pkg::ST_WAKE;
            tmr[0].load     = 1'b1;
            tmr[0].load_val = TW'(`RSS_SLEEP_WAKE_CYC);
          end
        rss_pkg::ST_DEEP:
          if (cmd_go && cmd_i == rss_pkg::CMD_OFF)
          begin
            state_nxt       = rss_pkg::ST_WAKE_DEEP;
            tmr[0].load     = 1'b1;
            tmr[0].load_val = TW'(POWERON_CYC);
          end
        rss_pkg::ST_OFF:
          if (cmd_go)
          begin
            case (cmd_i)
              rss_pkg::CMD_SLEEP:
                state_nxt = rss_pkg::ST_SLEEP;
              rss_pkg::CMD_DEEP_SLEEP:
                state_nxt = rss_pkg::ST_DEEP;
              rss_pkg::CMD_PREP:
              begin
                state_nxt       = rss_pkg::ST_PREP_SETTLE;
                tmr[0].load     = 1'b1;
                tmr[0].load_val = TW'(PREP_CYC);
              end
              rss_pkg::CMD_RX:
              begin
                state_nxt       = rss_pkg::ST_RX_SETTLE;
                tmr[0].load     = 1'b1;
                tmr[0].load_val = TW'(PREP_CYC);
              end
              default:
                state_nxt = state_r;
            endcase
          end
        rss_pkg::ST_PREP_SETTLE, rss_pkg::ST_RX_SETTLE:
          // Abort of a settling radio is allowed at any time
          if (cmd_go && cmd_i == rss_pkg::CMD_OFF)
            state_nxt = rss_pkg::ST_OFF;
          else if (tmr[0].done)
            state_nxt = (state_r == rss_pkg::ST_RX_SETTLE) ? rss_pkg::ST_RX : rss_pkg::ST_PREP;
        rss_pkg::ST_PREP:
          if (cmd_go && cmd_i == rss_pkg::CMD_OFF)
            state_nxt = rss_pkg::ST_OFF;
          else if (cmd_go && cmd_i == rss_pkg::CMD_RX)
            state_nxt = rss_pkg::ST_RX;
          else if (cmd_go && cmd_i == rss_pkg::CMD_TX && pll_locked_o)
          begin
            // Transmitting on an unsettled synthesiser would splatter
            state_nxt       = rss_pkg::ST_TX;
            tmr[0].load     = 1'b1;
            tmr[0].load_val = TW'(`RSS_TXSTART_CYC);
          end
        rss_pkg::ST_RX:
          if (cmd_go && cmd_i == rss_pkg::CMD_OFF)
            state_nxt = rss_pkg::ST_OFF;
          else if ((cmd_go && cmd_i == rss_pkg::CMD_PREP) || tmr[2].done)
            state_nxt = rss_pkg::ST_PREP;
        rss_pkg::ST_TX:
          if (cmd_go && cmd_i == rss_pkg::CMD_OFF)
            state_nxt = rss_pkg::ST_OFF;
          else if (tx_frame_end_i)
            state_nxt = rss_pkg::ST_PREP;
          else if (cmd_go && cmd_i == rss_pkg::CMD_PREP)
          begin
            if (pa_on_o)
            begin
              state_nxt       = rss_pkg::ST_RAMPDN;
              tmr[0].load     = 1'b1;
              tmr[0].load_val = TW'((32'(pa_ramp_time_field_i) + 32'd1) * `RSS_RAMP_STEP_CYC);
            end
            else
              state_nxt = rss_pkg::ST_PREP;
          end
        rss_pkg::ST_RAMPDN:
          if (cmd_go && cmd_i == rss_pkg::CMD_OFF)
            state_nxt = rss_pkg::ST_OFF;
          else if (tmr[0].done)
            state_nxt = rss_pkg::ST_PREP;
        default:
          state_nxt = rss_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      state_r <= rss_pkg::ST_POR;
    else
      state_r <= state_nxt;

  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      por_arm_r <= 1'b1;
    else
      por_arm_r <= 1'b0;

  assign state_o = state_r;

  // ****************************************************************
  // Interrupt pulses, aligned with the new state
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      power_up_done_irq_o <= 1'b0;
      radio_ready_irq_o   <= 1'b0;
      rx_frame_end_irq_o  <= 1'b0;
    end
    else
    begin
      power_up_done_irq_o <= (state_nxt == rss_pkg::ST_OFF) && hw_rst_n_s
                             && (state_r inside {rss_pkg::ST_POR, rss_pkg::ST_WAKE,
                                                 rss_pkg::ST_WAKE_DEEP});
      radio_ready_irq_o   <= (state_r == rss_pkg::ST_PREP_SETTLE)
                             && (state_nxt == rss_pkg::ST_PREP);
      rx_frame_end_irq_o  <= tmr[2].done;
    end

  // ****************************************************************
  // Frame-end processing and synthesiser settling
  // ****************************************************************
  assign tmr[2].load     = rx_valid_end_i && (state_r == rss_pkg::ST_RX);
  assign tmr[2].load_val = TW'(`RSS_RX_FRAME_END_IRQ_CYC);

  assign tmr[1].load     = chan_change_i && (state_r == rss_pkg::ST_PREP);
  assign tmr[1].load_val = TW'(`RSS_PLL_CYC);

  assign radio_on_nxt = state_nxt inside {rss_pkg::ST_PREP, rss_pkg::ST_RX,
                                          rss_pkg::ST_TX, rss_pkg::ST_RAMPDN};

  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      pll_locked_o <= 1'b0;
    else if (tmr[1].load || !radio_on_nxt)
      pll_locked_o <= 1'b0;
    else if (tmr[1].done || (state_r inside {rss_pkg::ST_PREP_SETTLE, rss_pkg::ST_RX_SETTLE}))
      pll_locked_o <= 1'b1;

  // ****************************************************************
  // Amplifier and clock output
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      pa_ramp_start_o <= 1'b0;
      pa_on_o         <= 1'b0;
    end
    else
    begin
      pa_ramp_start_o <= (state_r == rss_pkg::ST_TX) && (state_nxt == rss_pkg::ST_TX)
                         && tmr[0].done;
      pa_on_o         <= (state_nxt inside {rss_pkg::ST_TX, rss_pkg::ST_RAMPDN})
                         && (pa_on_o || (tmr[0].done && state_r == rss_pkg::ST_TX));
    end

  // Oscillator is down in deep sleep and until its wake-up completes
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      clock_out_pin_run_r      <= 1'b0;
      clock_out_pin_o <= 1'b0;
    end
    else
    begin
      clock_out_pin_run_r      <= !(state_nxt inside {rss_pkg::ST_POR, rss_pkg::ST_DEEP,
                                             rss_pkg::ST_WAKE_DEEP});
      clock_out_pin_o <= clock_out_pin_run_r && !clock_out_pin_o;
    end

  // ****************************************************************
  // Checks
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      st_cnt_r <= '0;
    else if (state_nxt != state_r)
      st_cnt_r <= '0;
    else if (st_cnt_r != '1)
      st_cnt_r <= st_cnt_r + 1'b1;

  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      pll_cnt_r <= '0;
    else if (tmr[1].load)
      pll_cnt_r <= '0;
    else if (tmr[1].busy)
      pll_cnt_r <= pll_cnt_r + 1'b1;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence cmd_s(rss_pkg::rss_cmd_type c);
    cmd_go && cmd_i == c;
  endsequence

  sequence in_s(rss_pkg::rss_state_type s);
    state_r == s && hw_rst_n_s;
  endsequence

  por_bound_a: assert property (state_r == rss_pkg::ST_POR |-> st_cnt_r < 12500)
    else $error("power-on wake too long");
  sleep_wake_a: assert property (in_s(rss_pkg::ST_SLEEP) ##0 cmd_s(rss_pkg::CMD_OFF)
                                 |-> ##[20:30] power_up_done_irq_o)
    else $error("sleep wake not within about 1 us");
  deep_wake_a: assert property (state_r == rss_pkg::ST_WAKE_DEEP |-> st_cnt_r < 12500)
    else $error("deep sleep wake too long");
  // A deep-sleep command may follow the wake at once, so only the first toggle is owed
  wake_clock_out_pin_a: assert property (power_up_done_irq_o |-> state_r == rss_pkg::ST_OFF
                                && clock_out_pin_run_r ##1 $changed(clock_out_pin_o))
    else $error("clock output not running after wake");
  rst_rel_a: assert property ($rose(hw_rst_n_s) |-> ##[20:30] state_r == rss_pkg::ST_OFF)
    else $error("reset release did not reach radio-off");
  prep_bound_a: assert property (state_r == rss_pkg::ST_PREP_SETTLE |-> st_cnt_r < 5000)
    else $error("prepare settling too long");
  ready_irq_a: assert property (radio_ready_irq_o |-> state_r == rss_pkg::ST_PREP
                                && $past(state_r) == rss_pkg::ST_PREP_SETTLE)
    else $error("ready interrupt without prepare arrival");
  rx_bound_a: assert property (state_r == rss_pkg::ST_RX_SETTLE |-> st_cnt_r < 5000)
    else $error("receive settling too long");
  tx_go_a: assert property (in_s(rss_pkg::ST_PREP) ##0 cmd_s(rss_pkg::CMD_TX)
                            ##0 pll_locked_o |=> state_r == rss_pkg::ST_TX)
    else $error("transmit not entered");
  pa_delay_a: assert property (pa_ramp_start_o |-> state_r == rss_pkg::ST_TX
                               && st_cnt_r == 16'd100)
    else $error("amplifier ramp start off time");
  prep_rx_a: assert property (in_s(rss_pkg::ST_PREP) ##0 cmd_s(rss_pkg::CMD_RX)
                              |=> state_r == rss_pkg::ST_RX)
    else $error("receive not entered from prepare");
  go_off_a: assert property (cmd_s(rss_pkg::CMD_OFF) ##0 state_r inside
                             {rss_pkg::ST_PREP, rss_pkg::ST_RX, rss_pkg::ST_TX}
                             |=> state_r == rss_pkg::ST_OFF)
    else $error("radio-off not reached");
  rx_prep_a: assert property (in_s(rss_pkg::ST_RX) ##0 (tmr[2].done
                              || (cmd_go && cmd_i == rss_pkg::CMD_PREP))
                              ##0 !(cmd_go && cmd_i == rss_pkg::CMD_OFF)
                              |=> state_r == rss_pkg::ST_PREP)
    else $error("receive did not return to prepare");
  txfe_a: assert property (in_s(rss_pkg::ST_TX) ##0 tx_frame_end_i
                           ##0 !(cmd_go && cmd_i == rss_pkg::CMD_OFF)
                           |=> state_r == rss_pkg::ST_PREP)
    else $error("transmit frame end did not return");
  rampdn_a: assert property (state_r == rss_pkg::ST_RAMPDN
                             && pa_ramp_time_field_i == `RSS_PARAMP_REF |-> st_cnt_r < 825)
    else $error("ramp-down too long");
  pll_win_a: assert property (tmr[1].done |-> pll_cnt_r >= 16'd249 && pll_cnt_r < 16'd2500)
    else $error("channel settle outside window");
  rx_frame_end_irq_a: assert property (in_s(rss_pkg::ST_RX) ##0 rx_valid_end_i
                           |-> ##[1:1000] rx_frame_end_irq_o)
    else $error("frame-end interrupt late");
endmodule

// [verif/rss_host.sv]
`timescale 1ns/10ps
module rss_host
(
  input  wire logic            mclk_i,
  output logic                 cmd_valid_o,
  output rss_pkg::rss_cmd_type cmd_o
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o       = rss_pkg::CMD_NOP;
  end

  // ****************************************************************
  // Command strobe
  // ****************************************************************
  // Returns on the taking edge, so every latency counts from here
  task automatic send(input rss_pkg::rss_cmd_type c);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_o       <= c;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    // Stale value would hide a design that ignores the strobe
    cmd_o       <= rss_pkg::rss_cmd_type'(~c);
  endtask

  // Host holds off dependent commands for the bounded move time
  task automatic idle(input int unsigned n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
endmodule

// [verif/radio_state_sequencer_bench.sv]
`timescale 1ns/10ps
`include "rss_regs.svh"
module radio_state_sequencer_bench;
  localparam int unsigned PON = 40;
  localparam int unsigned PRP = 30;

  logic                   mclk_i;
  logic                   rst_n_i;
  logic                   hw_rst_n;
  logic                   rxe;
  logic                   txe;
  logic                   chg;
  logic [1:0]             ramp;
  logic                   cmd_valid;
  rss_pkg::rss_cmd_type   cmd;
  rss_pkg::rss_state_type st;
  logic                   pud_irq;
  logic                   rdy_irq;
  logic                   rfe_irq;
  logic                   clk_out;
  logic                   ramp_start;
  logic                   pa_on;
  logic                   locked;
  int                     error_cnt;
  int                     comparisons;
  logic [31:0]            seed;
  int unsigned            n;
  logic [1:0]             f;
  logic                   a;

  rss_host host (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd));

  rss_top #(.POWERON_CYC(PON), .PREP_CYC(PRP)) dut
  (
    .mclk_i              (mclk_i),
    .rst_n_i             (rst_n_i),
    .hw_reset_input_n_i  (hw_rst_n),
    .cmd_valid_i         (cmd_valid),
    .cmd_i               (cmd),
    .rx_valid_end_i      (rxe),
    .tx_frame_end_i      (txe),
    .chan_change_i       (chg),
    .pa_ramp_time_field_i(ramp),
    .state_o             (st),
    .power_up_done_irq_o (pud_irq),
    .radio_ready_irq_o   (rdy_irq),
    .rx_frame_end_irq_o  (rfe_irq),
    .clock_out_pin_o     (clk_out),
    .pa_ramp_start_o     (ramp_start),
    .pa_on_o             (pa_on),
    .pll_locked_o        (locked)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Event pulse; returns on the edge that samples it
  task automatic ev(input int k);
    @(posedge mclk_i);
    rxe <= (k == 0);
    txe <= (k == 1);
    chg <= (k == 2);
    @(posedge mclk_i);
    rxe <= 1'b0;
    txe <= 1'b0;
    chg <= 1'b0;
  endtask

  task automatic wait_state(input rss_pkg::rss_state_type s, input int unsigned lim);
    n = 0;
    while (st !== s && n < lim)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
  endtask

  task automatic step(input rss_pkg::rss_cmd_type c, input int unsigned d,
                      input rss_pkg::rss_state_type s);
    host.send(c);
    host.idle(d);
    check(st, s);
  endtask

  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog, stimulus
  // ****************************************************************
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Whole sequence needs well under 10000 cycles
  initial
  begin
    #(40 * 30000);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    rst_n_i = 1'b0; hw_rst_n = 1'b1; rxe = 1'b0; txe = 1'b0; chg = 1'b0;
    ramp = 2'h0; error_cnt = 0; comparisons = 0; seed = 32'h0000005D;
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    host.idle(PON + 1);
    check(st, rss_pkg::ST_OFF);
    check(pud_irq, 1'b1);
    test_end("power_on");

    // No-op or transmit command in radio-off is dropped
    host.send((rnd() & 1) ? rss_pkg::CMD_TX : rss_pkg::CMD_NOP);
    host.idle(2);
    check(st, rss_pkg::ST_OFF);
    host.send(rss_pkg::CMD_RX);
    wait_state(rss_pkg::ST_RX, 6000);
    check(n <= `RSS_PREP_MAX_CYC, 1'b1);
    check(st, rss_pkg::ST_RX);
    step(rss_pkg::CMD_OFF, 1, rss_pkg::ST_OFF);
    step(rss_pkg::CMD_PREP, PRP, rss_pkg::ST_PREP);
    check({rdy_irq, locked}, 2'h3);
    step(rss_pkg::CMD_RX, 1, rss_pkg::ST_RX);
    step(rss_pkg::CMD_PREP, 1, rss_pkg::ST_PREP);
    test_end("off_prep_rx");

    ev(2);
    host.idle(1);
    check(locked, 1'b0);
    host.idle(1248);
    check(locked, 1'b0);
    host.idle(1);
    check(locked, 1'b1);
    test_end("channel");

    f = 2'(rnd());
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk_i);
      ramp <= f;
      host.idle(1 + rnd() % 4);
      step(rss_pkg::CMD_TX, 1, rss_pkg::ST_TX);
      host.idle(`RSS_TXSTART_CYC - 2);
      check(ramp_start, 1'b0);
      host.idle(1);
      check({ramp_start, pa_on}, 2'h3);
      step(rss_pkg::CMD_PREP, 1, rss_pkg::ST_RAMPDN);
      host.idle((f + 1) * `RSS_RAMP_STEP_CYC - 1);
      check({st, pa_on}, {rss_pkg::ST_PREP, 1'b0});
      check((f + 1) * `RSS_RAMP_STEP_CYC <= `RSS_RAMPDN_MAX_CYC, 1'b1);
      f = f + 2'h1;
    end
    test_end("tx_ramp");

    step(rss_pkg::CMD_TX, 1, rss_pkg::ST_TX);
    ev(1);
    host.idle(1);
    check(st, rss_pkg::ST_PREP);
    step(rss_pkg::CMD_RX, 1, rss_pkg::ST_RX);
    ev(0);
    host.idle(499);
    check(rfe_irq, 1'b0);
    host.idle(1);
    check({rfe_irq, st}, {1'b1, rss_pkg::ST_PREP});
    step(rss_pkg::CMD_TX, 1, rss_pkg::ST_TX);
    step(rss_pkg::CMD_OFF, 1, rss_pkg::ST_OFF);
    test_end("frame_end");

    host.send(rss_pkg::CMD_SLEEP);
    step(rss_pkg::CMD_OFF, `RSS_SLEEP_WAKE_CYC, rss_pkg::ST_OFF);
    check(pud_irq, 1'b1);
    host.send(rss_pkg::CMD_DEEP_SLEEP);
    step(rss_pkg::CMD_OFF, PON, rss_pkg::ST_OFF);
    check(pud_irq, 1'b1);
    host.idle(2);
    a = clk_out;
    host.idle(1);
    check(clk_out, !a);
    test_end("wake");

    @(posedge mclk_i);
    hw_rst_n <= 1'b0;
    host.idle(4);
    check(st, rss_pkg::ST_RST);
    @(posedge mclk_i);
    hw_rst_n <= 1'b1;
    wait_state(rss_pkg::ST_OFF, 200);
    check(st, rss_pkg::ST_OFF);
    check(n <= 2 * `RSS_RESET_CYC, 1'b1);
    test_end("hw_reset");
    report_and_stop();
  end
endmodule
